/* File: logic/gpi_consts.svh */
// Purpose: Offsets, field positions, sizes and fixed values of the GPI block
// Assumes: APB byte addresses, 32-bit data
// Notes:   Definitions only
`ifndef GPI_CONSTS_SVH
`define GPI_CONSTS_SVH

`define GPI_CTRL_OFS      12'h000
`define GPI_STATUS_OFS    12'h004
`define GPI_DELAY_OFS     12'h008
`define GPI_PIN_BASE      12'h100
`define GPI_PIN_LAST      12'h15C
`define GPI_SRC_BASE      12'h200
`define GPI_SRC_LAST      12'h27C
`define GPI_BANK_OUT_LSB  0
`define GPI_OVR_USER_BIT  3
`define GPI_OVR_ON_BIT    4
`define GPI_NEXT_GPO_BIT  5
`define GPI_SEL_BANK_LSB  6
`define GPI_PIN_DUR_LSB   8
`define GPI_SRC_PIN_LSB   8
`define GPI_AUX_SPECIAL   5'h1C
`define GPI_RECALL_BANK   4'h0
`define GPI_NUM_PINS      24
`define GPI_NUM_SRC       32

`endif

/* File: logic/gpi_pkg.sv */
// Purpose: Types of the GPI trigger and pre-delay block
// Assumes: Nothing
// Notes:   Zero-valued members are the reset values
package gpi_pkg;

  typedef enum logic [1:0] {
    active_low_pulse,
    active_high_pulse,
    active_low_latch,
    active_high_latch
  } output_type_t;

  typedef enum logic [1:0] {
    cut_kind,
    dissolve_type,
    wipe_kind,
    dve_kind
  } trans_kind_t;

  typedef enum logic [1:0] {
    idle_st,
    lookup_st,
    count_st
  } seq_state_t;

  typedef struct packed {
    logic [2:0]        bank_out;
    logic              ovr_user;
    logic              ovr_on;
    logic              next_gpo;
    logic [1:0]        sel_bank;
    logic [23:0][1:0]  pin_type;
    logic [23:0][7:0]  pin_dur;
    logic [23:0]       trig;
    logic [23:0][7:0]  pulse_cnt;
    logic [2:0][23:0]  in_sync;
    logic [23:0]       in_q;
    logic [2:0]        frame_sync;
    logic              frame_q;
    seq_state_t        seq;
    logic [4:0]        src;
    logic              skip;
    logic [7:0]        delay;
    logic [7:0]        lamp;
    logic [23:0]       level;
    logic [23:0]       action;
    logic              air_go;
    logic              air_cut;
    logic              fader_follow;
  } gpi_state_t;

endpackage : gpi_pkg

/* File: logic/src_table.sv */
// Purpose: Per-source table of output pin and pre-delay
// Assumes: One write port, two read ports with registered data
// Notes:   Contents undefined until written
`timescale 1ns/1ps
module src_table (
  input  wire logic        clk_sys,
  input  wire logic        wr_en,
  input  wire logic [4:0]  wr_addr,
  input  wire logic [12:0] wr_data,
  input  wire logic [4:0]  rd_addr_a,
  output logic      [12:0] rd_data_a,
  input  wire logic [4:0]  rd_addr_b,
  output logic      [12:0] rd_data_b
);
  logic [12:0] mem [0:31];

  always_ff @(posedge clk_sys)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
    rd_data_a <= mem[rd_addr_a];
    rd_data_b <= mem[rd_addr_b];
  end
endmodule : src_table

/* File: logic/gpi_trigger.sv */
// Purpose: GPI input triggers, output pulse/latch pins and transition pre-delay
// Assumes: APB slave, zero wait states; frame_ref is a reference frame pin
// Notes:   Pin n of the port is index n-1 of every 24-bit vector
`timescale 1ns/1ps
`include "gpi_consts.svh"
module gpi_trigger (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [23:0] gpi_in,
  output logic      [23:0] gpo_out,
  output logic      [23:0] gpo_oe,
  input  wire logic        frame_ref,
  input  wire logic        next_held,
  input  wire logic [7:0]  pattern_press,
  output logic      [7:0]  pattern_lamp,
  input  wire logic        take_req,
  input  wire logic [4:0]  take_src,
  input  wire logic [1:0]  take_kind,
  output logic             take_ready,
  input  wire logic        pgm_press,
  input  wire logic [4:0]  pgm_src,
  input  wire logic        fader_moved,
  output logic             air_go,
  output logic             air_cut,
  output logic             fader_follow,
  output logic      [23:0] action_pulse,
  output logic      [3:0]  recall_bank
);
  gpi_pkg::gpi_state_t st_reg;
  gpi_pkg::gpi_state_t st_next;
  logic [12:0] tab_a;
  logic [12:0] tab_b;
  logic        wr_acc;
  logic        rd_acc;
  logic        tab_hit;
  logic        pin_hit;
  logic        refuse;
  logic        tab_we;
  logic        frame_tick;
  logic [23:0] rise;

  function automatic logic in_range(input logic [11:0] a, input logic [11:0] lo,
                                    input logic [11:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction : in_range

  assign wr_acc  = psel && penable && pwrite;
  assign rd_acc  = psel && penable && !pwrite;
  assign tab_hit = in_range(paddr, `GPI_SRC_BASE, `GPI_SRC_LAST);
  assign pin_hit = in_range(paddr, `GPI_PIN_BASE, `GPI_PIN_LAST);
  assign refuse  = tab_hit && (paddr[6:2] >= `GPI_AUX_SPECIAL)
                   && (pwdata[12:8] != 5'h0_0);
  assign tab_we  = wr_acc && tab_hit && !refuse;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && ((!tab_hit && !pin_hit
                   && paddr != `GPI_CTRL_OFS && paddr != `GPI_STATUS_OFS
                   && paddr != `GPI_DELAY_OFS) || (pwrite && refuse));

  src_table u_table (
    .clk_sys   (clk_sys),
    .wr_en     (tab_we),
    .wr_addr   (paddr[6:2]),
    .wr_data   (pwdata[12:0]),
    .rd_addr_a (paddr[6:2]),
    .rd_data_a (tab_a),
    .rd_addr_b (take_src),
    .rd_data_b (tab_b)
  );

  // Agreed level changes only when stages two and three match
  assign frame_tick = st_reg.frame_sync[1] && st_reg.frame_sync[2] && !st_reg.frame_q;
  assign rise = st_reg.in_sync[1] & st_reg.in_sync[2] & ~st_reg.in_q;

  always_comb
  begin
    logic [1:0]  bk;
    logic        man;
    logic        auto_f;
    logic [4:0]  auto_pin;
    logic        wr_pin;
    bk       = 2'h0;
    man      = 1'b0;
    auto_f   = 1'b0;
    auto_pin = 5'h0_0;
    wr_pin   = 1'b0;
    st_next  = st_reg;
    st_next.air_go       = 1'b0;
    st_next.air_cut      = 1'b0;
    st_next.fader_follow = 1'b0;
    st_next.in_sync[0]    = gpi_in;
    st_next.in_sync[1]    = st_reg.in_sync[0];
    st_next.in_sync[2]    = st_reg.in_sync[1];
    st_next.frame_sync[0] = frame_ref;
    st_next.frame_sync[1] = st_reg.frame_sync[0];
    st_next.frame_sync[2] = st_reg.frame_sync[1];
    if (st_reg.frame_sync[1] == st_reg.frame_sync[2])
    begin
      st_next.frame_q = st_reg.frame_sync[2];
    end
    for (int p = 0; p < `GPI_NUM_PINS; p++)
    begin
      if (st_reg.in_sync[1][p] == st_reg.in_sync[2][p])
      begin
        st_next.in_q[p] = st_reg.in_sync[2][p];
      end
    end
    // Fixed pin-to-action map: action bit n is input pin n+1
    for (int b = 0; b < 3; b++)
    begin
      st_next.action[b*8 +: 8] = st_reg.bank_out[b] ? 8'h00 : rise[b*8 +: 8];
    end
    if (wr_acc && paddr == `GPI_CTRL_OFS)
    begin
      st_next.bank_out = pwdata[`GPI_BANK_OUT_LSB +: 3];
      st_next.ovr_user = pwdata[`GPI_OVR_USER_BIT];
      st_next.ovr_on   = pwdata[`GPI_OVR_ON_BIT];
      st_next.next_gpo = pwdata[`GPI_NEXT_GPO_BIT];
      st_next.sel_bank = pwdata[`GPI_SEL_BANK_LSB +: 2];
    end
    // Pre-delay sequencer
    unique case (st_reg.seq)
      gpi_pkg::idle_st:
      begin
        if (take_req)
        begin
          st_next.src  = take_src;
          st_next.skip = st_reg.ovr_user && !st_reg.ovr_on
                         && (take_kind != gpi_pkg::cut_kind);
          st_next.seq  = gpi_pkg::lookup_st;
        end
      end
      gpi_pkg::lookup_st:
      begin
        if (tab_b[12:8] == 5'h0_0 || tab_b[12:8] > 5'h18 || st_reg.skip)
        begin
          st_next.air_go = 1'b1;
          st_next.seq    = gpi_pkg::idle_st;
        end
        else
        begin
          auto_f   = 1'b1;
          auto_pin = tab_b[12:8];
          if (tab_b[7:0] == 8'h00)
          begin
            st_next.air_go = 1'b1;
            st_next.seq    = gpi_pkg::idle_st;
          end
          else
          begin
            st_next.delay = tab_b[7:0];
            st_next.seq   = gpi_pkg::count_st;
          end
        end
      end
      gpi_pkg::count_st:
      begin
        if (pgm_press && pgm_src == st_reg.src)
        begin
          st_next.air_cut = 1'b1;
          st_next.delay   = 8'h00;
          st_next.seq     = gpi_pkg::idle_st;
        end
        else if (fader_moved)
        begin
          st_next.fader_follow = 1'b1;
          st_next.delay        = 8'h00;
          st_next.seq          = gpi_pkg::idle_st;
        end
        else if (frame_tick)
        begin
          st_next.delay = st_reg.delay - 8'h01;
          if (st_reg.delay == 8'h01)
          begin
            st_next.air_go = 1'b1;
            st_next.seq    = gpi_pkg::idle_st;
          end
        end
      end
      default:
      begin
        st_next.seq = gpi_pkg::idle_st;
      end
    endcase

    // Output pins
    for (int p = 0; p < `GPI_NUM_PINS; p++)
    begin
      bk     = 2'(p / 8);
      man    = next_held && st_reg.next_gpo && st_reg.sel_bank == bk
               && st_reg.bank_out[bk] && pattern_press[p % 8];
      wr_pin = wr_acc && pin_hit && paddr[6:2] == 5'(p);
      if (!st_reg.pin_type[p][1])
      begin
        if (man || (auto_f && auto_pin == 5'(p + 1) && st_reg.bank_out[bk]))
        begin
          st_next.trig[p]      = 1'b1;
          st_next.pulse_cnt[p] = st_reg.pin_dur[p];
        end
        else if (frame_tick && st_reg.trig[p])
        begin
          st_next.pulse_cnt[p] = st_reg.pulse_cnt[p] - 8'h01;
          if (st_reg.pulse_cnt[p] <= 8'h01)
          begin
            st_next.trig[p] = 1'b0;
          end
        end
      end
      else if (man)
      begin
        st_next.trig[p] = !st_reg.trig[p];
      end
      else if (auto_f && auto_pin == 5'(p + 1) && st_reg.bank_out[bk])
      begin
        st_next.trig[p] = 1'b1;
      end
      if (wr_pin)
      begin
        st_next.pin_type[p]  = pwdata[1:0];
        st_next.pin_dur[p]   = pwdata[`GPI_PIN_DUR_LSB +: 8];
        st_next.trig[p]      = 1'b0;
        st_next.pulse_cnt[p] = 8'h00;
      end
      if (!st_next.bank_out[bk])
      begin
        st_next.trig[p]      = 1'b0;
        st_next.pulse_cnt[p] = 8'h00;
      end
      // Low-base types idle high, high-base types idle low
      st_next.level[p] = st_next.bank_out[bk]
                         && (!st_next.pin_type[p][0] ^ st_next.trig[p]);
    end
    st_next.lamp = (next_held && st_reg.sel_bank != 2'h3)
                   ? st_reg.trig[st_reg.sel_bank*8 +: 8] : 8'h00;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  always_comb
  begin
    prdata = 32'h0000_0000;
    if (rd_acc)
    begin
      if (paddr == `GPI_CTRL_OFS)
      begin
        prdata[7:0] = {st_reg.sel_bank, st_reg.next_gpo, st_reg.ovr_on,
                       st_reg.ovr_user, st_reg.bank_out};
      end
      else if (paddr == `GPI_STATUS_OFS)
      begin
        prdata = {6'h00, st_reg.seq, st_reg.trig};
      end
      else if (paddr == `GPI_DELAY_OFS)
      begin
        prdata[12:0] = {st_reg.src, st_reg.delay};
      end
      else if (pin_hit)
      begin
        prdata[15:0] = {st_reg.pin_dur[paddr[6:2]], 6'h00, st_reg.pin_type[paddr[6:2]]};
      end
      else if (tab_hit)
      begin
        prdata[12:0] = tab_a;
      end
    end
  end

  assign gpo_out      = st_reg.level;
  assign gpo_oe       = {{8{st_reg.bank_out[2]}}, {8{st_reg.bank_out[1]}},
                         {8{st_reg.bank_out[0]}}};
  assign pattern_lamp = st_reg.lamp;
  assign take_ready   = st_reg.seq == gpi_pkg::idle_st;
  assign air_go       = st_reg.air_go;
  assign air_cut      = st_reg.air_cut;
  assign fader_follow = st_reg.fader_follow;
  assign action_pulse = st_reg.action;
  assign recall_bank  = `GPI_RECALL_BANK;

  a_input_edge: assert property (@(posedge clk_sys) disable iff (!rst_n)
    action_pulse[0] |=> !action_pulse[0])
    else $error("input action lasted more than one cycle");
  a_input_bank: assert property (@(posedge clk_sys) disable iff (!rst_n)
    st_reg.bank_out[0] |=> action_pulse[7:0] == 8'h00)
    else $error("action from an output bank");
  a_skip_air: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (st_reg.seq == gpi_pkg::lookup_st && st_reg.skip) |=> air_go && gpo_out == $past(gpo_out))
    else $error("override off did not go straight to air");
  a_count_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (st_reg.seq == gpi_pkg::count_st && st_reg.delay > 8'h01) |=> !air_go)
    else $error("air before pre-delay ended");
  a_count_end: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (st_reg.seq == gpi_pkg::count_st && st_reg.delay == 8'h01 && frame_tick
     && !pgm_press && !fader_moved) |=> air_go && take_ready)
    else $error("pre-delay end did not put source on air");
  a_pgm_abort: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (st_reg.seq == gpi_pkg::count_st && pgm_press && pgm_src == st_reg.src)
    |=> air_cut && !air_go ##1 !air_cut)
    else $error("program press did not cut");
  a_fader_abort: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (st_reg.seq == gpi_pkg::count_st && fader_moved && !(pgm_press && pgm_src == st_reg.src))
    |=> fader_follow && take_ready)
    else $error("fader move did not cancel countdown");
  a_pulse_end: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (st_reg.trig[0] && !st_reg.pin_type[0][1] && st_reg.pulse_cnt[0] == 8'h01 && frame_tick
     && !pattern_press[0] && st_reg.seq != gpi_pkg::lookup_st) |=> !st_reg.trig[0])
    else $error("pulse outlived its duration");
  a_latch_toggle: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (st_reg.pin_type[0] == gpi_pkg::active_high_latch && st_reg.bank_out[0] && next_held
     && st_reg.next_gpo && st_reg.sel_bank == 2'h0 && pattern_press[0]
     && !(wr_acc && pin_hit)) |=> st_reg.trig[0] != $past(st_reg.trig[0]))
    else $error("latch did not toggle");
  a_input_low: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !st_reg.bank_out[1] |-> gpo_out[15:8] == 8'h00 && st_reg.trig[15:8] == 8'h00)
    else $error("input bank pin not low");
  a_lamp_show: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (next_held && st_reg.sel_bank == 2'h2) |=> pattern_lamp == $past(st_reg.trig[23:16]))
    else $error("lamps do not show bank state");
  a_aux_refuse: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (wr_acc && refuse) |-> pslverr && !tab_we)
    else $error("aux special association accepted");

  c_countdown: cover property (@(posedge clk_sys) disable iff (!rst_n)
    st_reg.seq == gpi_pkg::count_st ##1 air_go);
  c_pgm_cut: cover property (@(posedge clk_sys) disable iff (!rst_n) air_cut);
  c_fader: cover property (@(posedge clk_sys) disable iff (!rst_n) fader_follow);
  c_recall: cover property (@(posedge clk_sys) disable iff (!rst_n) action_pulse[23]);
endmodule : gpi_trigger

/* File: tb/ext_equipment.sv */
// Purpose: External equipment on the GPI pins
// Assumes: A pin nobody drives idles low
// Notes:   Pulses one pin high for seven cycles on request
`timescale 1ns/1ps
module ext_equipment (
  input  wire logic        clk_sys,
  input  wire logic        pulse_req,
  input  wire logic [4:0]  pulse_pin,
  input  wire logic [23:0] gpo_out,
  input  wire logic [23:0] gpo_oe,
  output logic      [23:0] gpi_in
);
  logic [23:0] drv_reg  = '0;
  logic [3:0]  hold_reg = '0;
  always @(posedge clk_sys)
  begin
    if (pulse_req)
    begin
      drv_reg  <= 24'h00_0001 << pulse_pin;
      hold_reg <= 4'h6;
    end
    else if (hold_reg != 4'h0)
      hold_reg <= hold_reg - 4'h1;
    else
      drv_reg <= '0;
  end
  // Block wins on pins it drives
  assign gpi_in = (gpo_oe & gpo_out) | (~gpo_oe & drv_reg);
endmodule : ext_equipment

/* File: tb/gpi_trigger_and_predelay_bench.sv */
// Purpose: Self-checking bench of the GPI trigger block
// Assumes: Zero-wait APB, frame reference period of 40 clocks
// Notes:   Outputs sampled on the falling edge, APB read data and pslverr on the rising edge
`timescale 1ns/1ps
`include "gpi_consts.svh"
module gpi_trigger_and_predelay_bench;
  logic        clk_sys = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, frame_ref = 0;
  logic        pready, pslverr, err, next_held = 0, take_req = 0, take_ready;
  logic        pgm_press = 0, fader_moved = 0, air_go, air_cut, fader_follow, pulse_req = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd, lfsr = 32'h0001_5BCC;
  logic [7:0]  pattern_press = '0, pattern_lamp;
  logic [4:0]  take_src = '0, pgm_src = '0, pulse_pin = '0;
  logic [1:0]  take_kind = '0;
  logic [23:0] gpi_in, gpo_out, gpo_oe, action_pulse;
  logic [3:0]  recall_bank;
  int          failures = 0, cmp_count = 0, fcnt = 0, fdiv = 0;

  always #2.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
  begin
    fdiv <= (fdiv == 19) ? 0 : fdiv + 1;
    if (fdiv == 19)
    begin
      frame_ref <= ~frame_ref;
      fcnt <= frame_ref ? fcnt : fcnt + 1;
    end
  end

  gpi_trigger dut_u (.clk_sys, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .gpi_in, .gpo_out, .gpo_oe, .frame_ref, .next_held, .pattern_press,
    .pattern_lamp, .take_req, .take_src, .take_kind, .take_ready, .pgm_press, .pgm_src,
    .fader_moved, .air_go, .air_cut, .fader_follow, .action_pulse, .recall_bank);
  ext_equipment ext_u (.clk_sys, .pulse_req, .pulse_pin, .gpo_out, .gpo_oe, .gpi_in);

  function automatic int rnd(input int m);
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return int'(lfsr % m);
  endfunction : rnd
  // User personality with override off skips all but cuts
  function automatic logic exp_skip(input int cf, input int kd);
    return cf == 1 && kd != 0;
  endfunction : exp_skip

  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic ok, input string m);
    cmp_count++;
    if (ok !== 1'b1)
    begin
      failures++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask : chk
  task automatic expire(input logic stuck);
    if (stuck)
    begin
      failures++;
      $display("ERROR %0t wait ran out", $time);
      print_verdict();
    end
  endtask : expire
  task automatic clk(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : clk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    psel   <= 1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    expire(pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 0;
    penable <= 0;
  endtask : apb
  task automatic sync_frame;
    int c;
    int n;
    c = fcnt;
    for (n = 0; n < 50 && fcnt == c; n++)
      @(posedge clk_sys);
    expire(fcnt == c);
    clk(10);
  endtask : sync_frame
  task automatic press(input int k);
    @(posedge clk_sys);
    pattern_press <= 8'h01 << k;
    @(posedge clk_sys);
    pattern_press <= '0;
    repeat (3) @(negedge clk_sys);
  endtask : press
  task automatic take(input int s, input int kd);
    @(posedge clk_sys);
    take_req  <= 1;
    take_src  <= 5'(s);
    take_kind <= 2'(kd);
    @(posedge clk_sys);
    take_req <= 0;
  endtask : take
  task automatic wait_end(output int fr, output logic [2:0] how);
    int n, f0;
    f0 = fcnt;
    how = '0;
    for (n = 0; how == 3'b000 && n < 1000; n++)
    begin
      @(negedge clk_sys);
      how = {fader_follow, air_cut, air_go};
    end
    expire(how == 3'b000);
    fr = fcnt - f0;
  endtask : wait_end

  initial
  begin : main
    logic [2:0]  how;
    logic [23:0] w;
    logic        b;
    int          k, s, d, c, fr, n;
    clk(5);
    rst_n <= 1;
    @(negedge clk_sys);
    chk(gpo_oe === '0 && gpo_out === '0 && take_ready === 1'b1, "reset state");
    for (k = 0; k < 24; k++)
    begin
      @(posedge clk_sys);
      pulse_pin <= 5'(k);
      pulse_req <= 1;
      @(posedge clk_sys);
      pulse_req <= 0;
      c = 0;
      b = 0;
      repeat (16)
      begin
        @(negedge clk_sys);
        c += (action_pulse !== '0);
        b |= (action_pulse === 24'h00_0001 << k);
      end
      chk(c == 1 && b, "input pin action");
    end
    chk(recall_bank === 4'h0, "recall bank");
    $display("Test input mapping done");
    apb(0, 12'h010, '0);
    chk(err === 1'b1 && rd === '0, "unmapped read");
    for (k = 28; k < 32; k++)
    begin
      apb(1, `GPI_SRC_BASE + 12'(4 * k), 32'h0000_0105);
      chk(err === 1'b1, "special source accepted");
    end
    $display("Test refusals done");
    apb(1, `GPI_CTRL_OFS, 32'h0000_0021);
    next_held <= 1;
    @(negedge clk_sys);
    chk(gpo_oe === 24'h00_00FF, "bank one enables");
    for (int r = 0; r < 3; r++)
    begin
      k = (r == 0) ? 0 : rnd(8);
      d = rnd(3) + 1;
      apb(1, `GPI_PIN_BASE + 12'(4 * k), {16'h0000, 8'(d), 8'(rnd(2))});
      sync_frame();
      b = gpo_out[k];
      c = fcnt;
      press(k);
      chk(gpo_out[k] === ~b && pattern_lamp === 8'h01 << k, "manual pulse");
      for (n = 0; gpo_out[k] === ~b && n < 500; n++)
        @(negedge clk_sys);
      expire(n >= 500);
      chk(fcnt - c == d, "pulse length");
    end
    k = 0;
    apb(1, `GPI_PIN_BASE + 12'(4 * k), 32'h0000_0003);
    clk(3);
    b = gpo_out[k];
    press(k);
    repeat (100) @(negedge clk_sys);
    chk(gpo_out[k] === ~b, "latch set and held");
    press(k);
    chk(gpo_out[k] === b, "latch released");
    press(k);
    apb(1, `GPI_PIN_BASE + 12'(4 * k), 32'h0000_0003);
    @(negedge clk_sys);
    chk(gpo_out[k] === b, "reconfig unlatch");
    for (int m = 0; m < 2; m++)
    begin
      apb(1, `GPI_CTRL_OFS, m ? 32'h0000_0001 : 32'h0000_0061);
      @(negedge clk_sys);
      w = gpo_out;
      press(rnd(8));
      chk(gpo_out === w, "manual press not ignored");
    end
    // Banks two and three as the manual bank
    for (int g = 1; g < 3; g++)
    begin
      apb(1, `GPI_CTRL_OFS, 32'h0000_0020 | (g << 6) | (1 << g));
      k = rnd(8);
      sync_frame();
      b = gpo_out[8 * g + k];
      press(k);
      chk(gpo_out[8 * g + k] === ~b && pattern_lamp === 8'h01 << k, "other bank press");
    end
    $display("Test manual triggers done");
    s = rnd(28);
    k = rnd(8);
    apb(1, `GPI_SRC_BASE + 12'(4 * s), {19'h0_0000, 5'(k + 1), 8'h02});
    chk(err === 1'b0, "source write refused");
    apb(0, `GPI_SRC_BASE + 12'(4 * s), '0);
    chk(rd[12:0] === {5'(k + 1), 8'h02}, "source table read");
    for (int i = 0; i < 16; i++)
    begin
      apb(1, `GPI_CTRL_OFS, 32'h0000_0021 | ((i / 4) << 3));
      apb(1, `GPI_PIN_BASE + 12'(4 * k), 32'h0000_0003);
      sync_frame();
      b = gpo_out[k];
      take(s, i % 4);
      wait_end(fr, how);
      c = exp_skip(i / 4, i % 4) ? 0 : 2;
      chk(how === 3'b001 && fr == c && gpo_out[k] === (c != 0 ? ~b : b), "take");
    end
    apb(1, `GPI_CTRL_OFS, 32'h0000_0021);
    apb(1, `GPI_SRC_BASE + 12'(4 * s), {19'h0_0000, 5'(k + 1), 8'h03});
    for (int a = 0; a < 2; a++)
    begin
      sync_frame();
      take(s, 1);
      apb(0, `GPI_DELAY_OFS, '0);
      chk(rd[12:0] === {5'(s), 8'h03}, "countdown state");
      pgm_src     <= 5'(s + a);
      pgm_press   <= 1;
      fader_moved <= a[0];
      clk(1);
      pgm_press   <= 0;
      fader_moved <= 0;
      wait_end(fr, how);
      chk(how === (a ? 3'b100 : 3'b010) && fr == 0, "countdown abort");
    end
    $display("Test transitions done");
    apb(1, `GPI_CTRL_OFS, 32'h0000_0000);
    @(negedge clk_sys);
    chk(gpo_oe === '0 && gpo_out[7:0] === 8'h00, "bank to input");
    $display("Test bank switch done");
    print_verdict();
  end

  initial
  begin
    clk(100000);
    expire(1'b1);
  end
endmodule : gpi_trigger_and_predelay_bench
